// ===== verilog/dgc_general_regs.sv
// General control register bank of the deserializer behind the serial control bus
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Address field bits 7:1 load the strap-selected 7-bit address after reset.
// - Bit 0 clear answers at strap address; set uses programmed address.
// - Full soft reset bit clears logic and all registers, then clears itself.
// - Full soft reset reloads strap-derived registers from the current strap.
// - Logic-only soft reset clears logic, keeps registers, then clears itself.
// - Without override the effective output enable is forced to 1.
// - Override bit selects written enable and sleep values over defaults.
// - Oscillator enable plus lost lock, outside a logic reset, drives oscillator clock on osc_clk_out.
// - Sleep select with output enable sets output state while unlocked.
// - Without override the effective sleep select is forced to 1.
module dgc_general_regs (
	input  wire logic              core_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe_out,
	input  wire logic [2:0]        address_strap_pin_in,
	input  wire logic              lock_in,
	output logic                   logic_reset_out,
	output logic                   output_enable_out,
	output logic                   output_sleep_state_select_out,
	output dgc_pkg::dgc_out_mode_e output_mode_out,
	output logic                   osc_active_out,
	output logic                   osc_clk_out
);
	localparam int CNT_W = $clog2(dgc_pkg::SOFT_RST_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(dgc_pkg::SOFT_RST_CYCLES);

	dgc_bus_if bus ();

	logic [2:0]       strap_meta, strap_sync;
	logic [6:0]       strap_addr;
	logic [7:0]       bus_address_config, next_bus_address_config;
	logic [4:0]       soft_rst_hi, next_soft_rst_hi;
	logic [7:0]       output_general_config, next_output_general_config;
	logic [CNT_W-1:0] full_cnt, next_full_cnt;
	logic [CNT_W-1:0] logic_cnt, next_logic_cnt;
	logic             next_logic_reset;
	logic             full_busy, logic_busy;
	logic             wr_bus_addr, wr_soft_rst, wr_out_cfg;
	logic             full_soft_reset, logic_only_soft_reset;

	// Strap level is analog on the board side, so it is synchronised first
	always_ff @(posedge core_clk_in) begin
		strap_meta <= address_strap_pin_in;
		strap_sync <= strap_meta;
	end

	assign strap_addr = dgc_pkg::dgc_strap_to_addr(strap_sync);
	assign full_busy  = (full_cnt != '0);
	assign logic_busy = (logic_cnt != '0);

	// Readback of the soft reset register
	function automatic logic [7:0] soft_rst_view(input logic [4:0] hi, input logic full,
		input logic lgc);
		logic [7:0] v;
		v = {hi, 3'h0};
		v[dgc_pkg::RST_FIXED_BIT] = 1'b1;
		v[dgc_pkg::FULL_RST_BIT]  = full;
		v[dgc_pkg::LOGIC_RST_BIT] = lgc;
		return v;
	endfunction : soft_rst_view

	// Address answered on the bus
	always_comb begin
		if (bus_address_config[dgc_pkg::ADDR_SRC_BIT])
			bus.dev_addr = bus_address_config[7:1];
		else
			bus.dev_addr = strap_addr;
	end

	// Register read, unmapped offsets read as zero
	always_comb begin
		unique case (bus.rd_addr)
			dgc_pkg::REG_BUS_ADDR: bus.rd_data = bus_address_config;
			dgc_pkg::REG_SOFT_RST: bus.rd_data = soft_rst_view(soft_rst_hi, full_busy,
				logic_busy);
			dgc_pkg::REG_OUT_CFG:  bus.rd_data = output_general_config;
			default:               bus.rd_data = 8'h00;
		endcase
	end

	assign wr_bus_addr = bus.wr_stb && bus.wr_addr == dgc_pkg::REG_BUS_ADDR;
	assign wr_soft_rst = bus.wr_stb && bus.wr_addr == dgc_pkg::REG_SOFT_RST;
	assign wr_out_cfg  = bus.wr_stb && bus.wr_addr == dgc_pkg::REG_OUT_CFG;
	assign full_soft_reset       = wr_soft_rst && bus.wr_data[dgc_pkg::FULL_RST_BIT];
	assign logic_only_soft_reset = wr_soft_rst && bus.wr_data[dgc_pkg::LOGIC_RST_BIT];

	always_comb begin
		next_bus_address_config    = bus_address_config;
		next_soft_rst_hi           = soft_rst_hi;
		next_output_general_config = output_general_config;
		next_full_cnt  = full_busy ? full_cnt - CNT_W'(1) : full_cnt;
		next_logic_cnt = logic_busy ? logic_cnt - CNT_W'(1) : logic_cnt;
		if (wr_bus_addr)
			next_bus_address_config = bus.wr_data;
		if (wr_soft_rst)
			next_soft_rst_hi = bus.wr_data[7:3];
		if (wr_out_cfg)
			next_output_general_config = bus.wr_data;
		if (full_soft_reset)
			next_full_cnt = CNT_LOAD;
		if (logic_only_soft_reset)
			next_logic_cnt = CNT_LOAD;
		// Reload takes priority over any write landing during the reset window
		if (full_busy) begin
			next_bus_address_config    = {strap_addr, 1'b0};
			next_soft_rst_hi           = dgc_pkg::SOFT_RST_HI_RESET;
			next_output_general_config = dgc_pkg::OUT_CFG_RESET;
		end
		next_logic_reset = (next_full_cnt != '0) || (next_logic_cnt != '0);
	end

	// Address register takes the synchronised strap, so reset is held three edges
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			bus_address_config    <= {strap_addr, 1'b0};
			soft_rst_hi           <= dgc_pkg::SOFT_RST_HI_RESET;
			output_general_config <= dgc_pkg::OUT_CFG_RESET;
			full_cnt              <= '0;
			logic_cnt             <= '0;
			logic_reset_out       <= 1'b0;
		end else begin
			bus_address_config    <= next_bus_address_config;
			soft_rst_hi           <= next_soft_rst_hi;
			output_general_config <= next_output_general_config;
			full_cnt              <= next_full_cnt;
			logic_cnt             <= next_logic_cnt;
			logic_reset_out       <= next_logic_reset;
		end
	end

	dgc_serial_slave u_slave (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.scl_in      (scl_in),
		.sda_in      (sda_in),
		.sda_out     (sda_out),
		.sda_oe_out  (sda_oe_out),
		.bus         (bus.engine)
	);

	dgc_output_ctrl u_out (
		.core_clk_in       (core_clk_in),
		.rst_n_in          (rst_n_in),
		.logic_rst_in      (logic_reset_out),
		.lock_in           (lock_in),
		.cfg_in            (output_general_config),
		.output_enable_out (output_enable_out),
		.sleep_state_out   (output_sleep_state_select_out),
		.output_mode_out   (output_mode_out),
		.osc_active_out    (osc_active_out),
		.osc_clk_out       (osc_clk_out)
	);

	AST_STRAP_AT_RESET: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		$rose(rst_n_in) |-> bus_address_config == {$past(strap_addr), 1'b0})
		else $error("address register not loaded from strap after reset");

	sequence reset_window_s;
		logic_reset_out [*2] ##1 !logic_reset_out;
	endsequence

	AST_FULL_RESET_PULSE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(full_soft_reset && !full_busy && !logic_busy) |=> full_busy ##0 reset_window_s)
		else $error("full soft reset pulse wrong length or not self-clearing");

	AST_STRAP_RELOAD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(full_busy && !$past(full_busy)) |=> (bus_address_config == {$past(strap_addr), 1'b0}
			&& output_general_config == dgc_pkg::OUT_CFG_RESET))
		else $error("full soft reset did not reload strap value");

	AST_LOGIC_RESET_KEEPS_REGS: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		(logic_only_soft_reset && !full_soft_reset && !full_busy && !logic_busy)
			|=> ($stable(bus_address_config) && logic_reset_out) ##1 logic_reset_out
			##1 (!logic_reset_out && !logic_busy))
		else $error("logic-only soft reset altered registers or did not clear");

	AST_FIXED_BIT_READS_ONE: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in)
		bus.rd_addr == dgc_pkg::REG_SOFT_RST |-> (bus.rd_data[dgc_pkg::RST_FIXED_BIT]
			&& bus.rd_data[7:3] == soft_rst_hi))
		else $error("reset register fixed bit not read as one");

endmodule : dgc_general_regs
`default_nettype wire

// ===== verilog/dgc_pkg.sv
// Constants, register map and strap decode for the general control register bank
package dgc_pkg;

	// Register offsets
	localparam logic [7:0] REG_BUS_ADDR    = 8'h00;
	localparam logic [7:0] REG_SOFT_RST    = 8'h01;
	localparam logic [7:0] REG_OUT_CFG     = 8'h02;

	// Field positions
	localparam int ADDR_SRC_BIT   = 0;
	localparam int LOGIC_RST_BIT  = 0;
	localparam int FULL_RST_BIT   = 1;
	localparam int RST_FIXED_BIT  = 2;
	localparam int OSS_BIT        = 4;
	localparam int OSC_EN_BIT     = 5;
	localparam int OVR_BIT        = 6;
	localparam int OE_BIT         = 7;

	// Values after reset
	localparam logic [4:0] SOFT_RST_HI_RESET = 5'h00;
	localparam logic [7:0] OUT_CFG_RESET     = 8'h00;

	// Cycle counts
	localparam int SOFT_RST_CYCLES = 2;
	localparam int OSC_HALF_CYCLES = 2;

	typedef enum logic [1:0] {
		DGC_OUT_ACTIVE,
		DGC_OUT_HELD_LOW,
		DGC_OUT_DISABLED
	} dgc_out_mode_e;

	// Strap level index to 7-bit bus address
	function automatic logic [6:0] dgc_strap_to_addr(input logic [2:0] idx);
		logic [6:0] a;
		a = 7'h2C;
		unique case (idx)
			3'h0: a = 7'h2C;
			3'h1: a = 7'h2E;
			3'h2: a = 7'h30;
			3'h3: a = 7'h32;
			3'h4: a = 7'h34;
			3'h5: a = 7'h36;
			3'h6: a = 7'h38;
			3'h7: a = 7'h3C;
		endcase
		return a;
	endfunction : dgc_strap_to_addr

endpackage : dgc_pkg

// ===== verilog/dgc_bus_if.sv
// Byte access channel between the serial slave engine and the register bank
`timescale 1ns/1ps
`default_nettype none
interface dgc_bus_if;
	logic [6:0] dev_addr;
	logic       wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;

	modport engine (input dev_addr, input rd_data, output wr_stb, output wr_addr,
		output wr_data, output rd_addr);
	modport regs (output dev_addr, output rd_data, input wr_stb, input wr_addr,
		input wr_data, input rd_addr);
endinterface : dgc_bus_if
`default_nettype wire

// ===== verilog/dgc_serial_slave.sv
// Serial control bus slave: start/stop detect, address match, byte read and write
`timescale 1ns/1ps
`default_nettype none
module dgc_serial_slave (
	input  wire logic  core_clk_in,
	input  wire logic  rst_n_in,
	input  wire logic  scl_in,
	input  wire logic  sda_in,
	output logic       sda_out,
	output logic       sda_oe_out,
	dgc_bus_if.engine  bus
);
	typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_DONE, S_ACK, S_TX, S_TX_ACK} dgc_slv_state_e;

	logic           scl_meta, scl_sync, scl_prev;
	logic           sda_meta, sda_sync, sda_prev;
	dgc_slv_state_e st, next_st;
	logic [2:0]     cnt, next_cnt;
	logic [1:0]     idx, next_idx;
	logic [7:0]     sh, next_sh;
	logic [7:0]     ptr, next_ptr;
	logic [7:0]     wr_addr, next_wr_addr;
	logic           rw, next_rw;
	logic           drv, next_drv;
	logic           wr_stb, next_wr_stb;
	logic           scl_rise, scl_fall, start, stop;

	// Synchronisers, third stage only for edge detection
	always_ff @(posedge core_clk_in) begin
		scl_meta <= scl_in;
		scl_sync <= scl_meta;
		scl_prev <= scl_sync;
		sda_meta <= sda_in;
		sda_sync <= sda_meta;
		sda_prev <= sda_sync;
	end

	assign scl_rise = scl_sync & ~scl_prev;
	assign scl_fall = ~scl_sync & scl_prev;
	assign start    = scl_sync & scl_prev & sda_prev & ~sda_sync;
	assign stop     = scl_sync & scl_prev & ~sda_prev & sda_sync;

	always_comb begin
		next_st      = st;
		next_cnt     = cnt;
		next_idx     = idx;
		next_sh      = sh;
		next_ptr     = ptr;
		next_wr_addr = wr_addr;
		next_rw      = rw;
		next_drv     = drv;
		next_wr_stb  = 1'b0;
		if (start) begin
			next_st  = S_RX;
			next_cnt = 3'h0;
			next_idx = 2'h0;
			next_drv = 1'b0;
		end else if (stop) begin
			next_st  = S_IDLE;
			next_drv = 1'b0;
		end else begin
			unique case (st)
				S_IDLE: begin
				end
				S_RX: if (scl_rise) begin
					next_sh  = {sh[6:0], sda_sync};
					next_cnt = cnt + 3'h1;
					if (cnt == 3'h7)
						next_st = S_RX_DONE;
				end
				S_RX_DONE: if (scl_fall) begin
					next_st  = S_ACK;
					next_drv = 1'b1;
					next_idx = (idx == 2'h2) ? 2'h2 : idx + 2'h1;
					if (idx == 2'h0) begin
						if (sh[7:1] != bus.dev_addr) begin
							next_st  = S_IDLE;
							next_drv = 1'b0;
						end else begin
							next_rw = sh[0];
						end
					end else if (idx == 2'h1) begin
						next_ptr = sh;
					end else begin
						next_wr_stb  = 1'b1;
						next_wr_addr = ptr;
						next_ptr     = ptr + 8'h01;
					end
				end
				S_ACK: if (scl_fall) begin
					next_cnt = 3'h0;
					if (rw) begin
						next_st  = S_TX;
						next_sh  = bus.rd_data;
						next_drv = ~bus.rd_data[7];
						next_ptr = ptr + 8'h01;
					end else begin
						next_st  = S_RX;
						next_drv = 1'b0;
					end
				end
				S_TX: if (scl_fall) begin
					next_cnt = cnt + 3'h1;
					next_sh  = {sh[6:0], 1'b0};
					if (cnt == 3'h7) begin
						next_st  = S_TX_ACK;
						next_drv = 1'b0;
					end else begin
						next_drv = ~sh[6];
					end
				end
				S_TX_ACK: if (scl_rise)
					next_st = sda_sync ? S_IDLE : S_ACK;
			endcase
		end
	end

	// Engine is kept out of soft resets so a resetting write still gets its ACK
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			st      <= S_IDLE;
			cnt     <= 3'h0;
			idx     <= 2'h0;
			sh      <= 8'h00;
			ptr     <= 8'h00;
			wr_addr <= 8'h00;
			rw      <= 1'b0;
			drv     <= 1'b0;
			wr_stb  <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			st      <= next_st;
			cnt     <= next_cnt;
			idx     <= next_idx;
			sh      <= next_sh;
			ptr     <= next_ptr;
			wr_addr <= next_wr_addr;
			rw      <= next_rw;
			drv     <= next_drv;
			wr_stb  <= next_wr_stb;
			sda_out <= 1'b0;
		end
	end

	assign sda_oe_out  = drv;
	assign bus.wr_stb  = wr_stb;
	assign bus.wr_addr = wr_addr;
	assign bus.wr_data = sh;
	assign bus.rd_addr = ptr;

	AST_ADDR_MISMATCH_NACK: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(st == S_RX_DONE && scl_fall && idx == 2'h0 && !start && !stop
			&& sh[7:1] != bus.dev_addr) |=> (!drv && st == S_IDLE))
		else $error("address mismatch was acknowledged");

	AST_DATA_WRITE_ACK: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(st == S_RX_DONE && scl_fall && idx == 2'h2 && !start && !stop)
			|=> (drv && wr_stb) ##1 (!wr_stb && drv))
		else $error("data byte write not strobed and acknowledged");

endmodule : dgc_serial_slave
`default_nettype wire

// ===== verilog/dgc_output_ctrl.sv
// Effective output enable, sleep state and free-running oscillator clock output
`timescale 1ns/1ps
`default_nettype none
module dgc_output_ctrl (
	input  wire logic            core_clk_in,
	input  wire logic            rst_n_in,
	input  wire logic            logic_rst_in,
	input  wire logic            lock_in,
	input  wire logic [7:0]      cfg_in,
	output logic                 output_enable_out,
	output logic                 sleep_state_out,
	output dgc_pkg::dgc_out_mode_e output_mode_out,
	output logic                 osc_active_out,
	output logic                 osc_clk_out
);
	localparam int DIV_W = $clog2(dgc_pkg::OSC_HALF_CYCLES + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(dgc_pkg::OSC_HALF_CYCLES - 1);

	logic                   cfg_ovr, cfg_oe, cfg_oss, cfg_osc, osc_go;
	logic                   next_oe, next_oss, next_osc_act, next_osc_clk;
	dgc_pkg::dgc_out_mode_e next_mode;
	logic [DIV_W-1:0]       div, next_div;

	assign cfg_ovr = cfg_in[dgc_pkg::OVR_BIT];
	assign cfg_oe  = cfg_in[dgc_pkg::OE_BIT];
	assign cfg_oss = cfg_in[dgc_pkg::OSS_BIT];
	assign cfg_osc = cfg_in[dgc_pkg::OSC_EN_BIT];
	assign osc_go  = cfg_osc & ~lock_in & ~logic_rst_in;

	always_comb begin
		next_oe  = cfg_ovr ? cfg_oe : 1'b1;
		next_oss = cfg_ovr ? cfg_oss : 1'b1;
		if (!next_oe)
			next_mode = dgc_pkg::DGC_OUT_DISABLED;
		else if (lock_in)
			next_mode = dgc_pkg::DGC_OUT_ACTIVE;
		else
			next_mode = next_oss ? dgc_pkg::DGC_OUT_HELD_LOW : dgc_pkg::DGC_OUT_DISABLED;
		next_osc_act = osc_go;
		next_div     = div;
		next_osc_clk = osc_clk_out;
		if (!osc_go) begin
			next_div     = '0;
			next_osc_clk = 1'b0;
		end else if (div == DIV_LAST) begin
			next_div     = '0;
			next_osc_clk = ~osc_clk_out;
		end else begin
			next_div = div + DIV_W'(1);
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			output_enable_out <= 1'b1;
			sleep_state_out   <= 1'b1;
			output_mode_out   <= dgc_pkg::DGC_OUT_DISABLED;
			osc_active_out    <= 1'b0;
			osc_clk_out       <= 1'b0;
			div               <= '0;
		end else begin
			output_enable_out <= next_oe;
			sleep_state_out   <= next_oss;
			output_mode_out   <= next_mode;
			osc_active_out    <= next_osc_act;
			osc_clk_out       <= next_osc_clk;
			div               <= next_div;
		end
	end

	AST_OE_FORCED: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		!cfg_ovr |=> output_enable_out)
		else $error("output enable not forced high without override");

	AST_OSS_FORCED: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		!cfg_ovr |=> sleep_state_out)
		else $error("sleep state not forced high without override");

	AST_OVERRIDE_VALUES: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		cfg_ovr |=> (output_enable_out == $past(cfg_oe) && sleep_state_out == $past(cfg_oss)))
		else $error("override values not applied");

	AST_LOCK_LOW_MODE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(!lock_in && next_oe) |=>
			(output_mode_out == ($past(next_oss) ? dgc_pkg::DGC_OUT_HELD_LOW
				: dgc_pkg::DGC_OUT_DISABLED)))
		else $error("output state wrong while unlocked");

	sequence osc_start_s;
		!osc_go ##1 osc_go [*3];
	endsequence

	AST_OSC_RUNS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		osc_start_s |=> (osc_active_out && osc_clk_out))
		else $error("oscillator clock not driven after loss of lock");

	AST_OSC_STOPS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		!osc_go |=> (!osc_active_out && !osc_clk_out))
		else $error("oscillator clock driven while locked or disabled");

endmodule : dgc_output_ctrl
`default_nettype wire

// ===== dv/dgc_host_model.sv
// Serial control bus master model driving the register bank from the host side
`timescale 1ns/1ps
`default_nettype none
module dgc_host_model (
	input  wire logic core_clk_in,
	input  wire logic dev_pull_in,
	output logic      scl_out,
	output wire logic sda_out
);
	logic m_low;

	// Open-drain line with pull-up: low if either party pulls
	assign sda_out = ~(m_low | dev_pull_in);

	initial begin
		scl_out = 1'b1;
		m_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk_in);
	endtask : tick

	// Data moves only mid low phase, so no false start or stop is seen
	task automatic put_bit(input logic b, output logic seen);
		m_low = ~b;
		tick(5);
		scl_out = 1'b1;
		tick(5);
		seen = sda_out;
		tick(5);
		scl_out = 1'b0;
		tick(5);
	endtask : put_bit

	task automatic bus_start;
		m_low = 1'b0;
		tick(5);
		scl_out = 1'b1;
		tick(5);
		m_low = 1'b1;
		tick(5);
		scl_out = 1'b0;
		tick(5);
	endtask : bus_start

	task automatic bus_stop;
		m_low = 1'b1;
		tick(5);
		scl_out = 1'b1;
		tick(5);
		m_low = 1'b0;
		tick(10);
	endtask : bus_stop

	// Most significant bit first, then the acknowledge slot
	task automatic xfer_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], s);
			q[i] = s;
		end
		put_bit(ack_in, s);
		ack = ~s;
	endtask : xfer_byte

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
		output logic ack);
		logic [7:0] q;
		logic       a1;
		logic       a2;
		logic       a3;
		bus_start();
		xfer_byte({dev, 1'b0}, 1'b1, q, a1);
		xfer_byte(ptr, 1'b1, q, a2);
		xfer_byte(d, 1'b1, q, a3);
		bus_stop();
		ack = a1 & a2 & a3;
	endtask : write_reg

	// Pointer write, repeated start, one byte closed by a NACK
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d,
		output logic ack);
		logic [7:0] q;
		logic       a1;
		logic       a2;
		logic       a3;
		bus_start();
		xfer_byte({dev, 1'b0}, 1'b1, q, a1);
		xfer_byte(ptr, 1'b1, q, a2);
		bus_start();
		xfer_byte({dev, 1'b1}, 1'b1, q, a3);
		xfer_byte(8'hFF, 1'b1, d, a1);
		bus_stop();
		ack = a2 & a3;
	endtask : read_reg
endmodule : dgc_host_model
`default_nettype wire

// ===== dv/deser_general_control_regs_bench.sv
// Self-checking bench for the general control register bank
`timescale 1ns/1ps
`default_nettype none
module deser_general_control_regs_bench;
	localparam logic [6:0] ADDR_TAB [8] = '{7'h2C, 7'h2E, 7'h30, 7'h32, 7'h34, 7'h36, 7'h38, 7'h3C};

	logic                   core_clk_in;
	logic                   rst_n_in;
	logic                   lock;
	logic [2:0]             strap;
	wire                    scl;
	wire                    sda;
	logic                   sda_oe;
	logic                   sda_drv;
	logic                   logic_rst;
	logic                   oe;
	logic                   sleep;
	dgc_pkg::dgc_out_mode_e mode;
	logic                   osc_act;
	logic                   osc_clk;
	logic [7:0]             mreg [3];
	int                     fail_count = 0;
	int                     samples_checked = 0;
	int                     rst_run = 0;
	int                     rst_len = 0;
	int                     rst_pulses = 0;
	int                     cycles = 0;
	int unsigned            seed_v;

	dgc_general_regs u_dgc_general_regs (
		.core_clk_in                   (core_clk_in),
		.rst_n_in                      (rst_n_in),
		.scl_in                        (scl),
		.sda_in                        (sda),
		.sda_out                       (sda_drv),
		.sda_oe_out                    (sda_oe),
		.address_strap_pin_in          (strap),
		.lock_in                       (lock),
		.logic_reset_out               (logic_rst),
		.output_enable_out             (oe),
		.output_sleep_state_select_out (sleep),
		.output_mode_out               (mode),
		.osc_active_out                (osc_act),
		.osc_clk_out                   (osc_clk)
	);

	dgc_host_model u_dgc_host_model (
		.core_clk_in (core_clk_in),
		.dev_pull_in (sda_oe),
		.scl_out     (scl),
		.sda_out     (sda)
	);

	always #10 core_clk_in = ~core_clk_in;

	// Length of each soft reset pulse
	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (logic_rst === 1'b1) begin
			rst_run <= rst_run + 1;
		end else begin
			if (rst_run > 0) begin
				rst_len <= rst_run;
				rst_pulses <= rst_pulses + 1;
			end
			rst_run <= 0;
		end
		if (cycles == 90000) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict

	function automatic logic [6:0] cur_dev();
		return mreg[0][0] ? mreg[0][7:1] : ADDR_TAB[strap];
	endfunction : cur_dev

	task automatic model_reset;
		mreg[0] = {ADDR_TAB[strap], 1'b0};
		mreg[1] = 8'h04;
		mreg[2] = 8'h00;
	endtask : model_reset

	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		logic a;
		int   p0;
		p0 = rst_pulses;
		u_dgc_host_model.write_reg(cur_dev(), ptr, d, a);
		check("write_ack", {7'h0, a}, 8'h01);
		if (ptr == 8'h00) mreg[0] = d;
		if (ptr == 8'h02) mreg[2] = d;
		if (ptr == 8'h01) begin
			mreg[1] = {d[7:3], 3'b100};
			check("rst_pulses", 8'(rst_pulses - p0), {7'h0, |d[1:0]});
			if (|d[1:0]) check("rst_len", 8'(rst_len), 8'(dgc_pkg::SOFT_RST_CYCLES));
			if (d[1]) model_reset();
		end
	endtask : wr

	task automatic check_regs;
		logic [7:0] q;
		logic       a;
		for (int r = 0; r < 3; r++) begin
			u_dgc_host_model.read_reg(cur_dev(), 8'(r), q, a);
			check("read_ack", {7'h0, a}, 8'h01);
			check("reg", q, mreg[r]);
			check("sda_out", {7'h0, sda_drv}, 8'h00);
		end
	endtask : check_regs

	task automatic check_outputs;
		logic       eo;
		logic       es;
		logic       oa;
		logic [1:0] em;
		logic       prev;
		int         t;
		eo = mreg[2][6] ? mreg[2][7] : 1'b1;
		es = mreg[2][6] ? mreg[2][4] : 1'b1;
		oa = mreg[2][5] & ~lock;
		em = !eo ? dgc_pkg::DGC_OUT_DISABLED : lock ? dgc_pkg::DGC_OUT_ACTIVE :
			es ? dgc_pkg::DGC_OUT_HELD_LOW : dgc_pkg::DGC_OUT_DISABLED;
		check("oe", {7'h0, oe}, {7'h0, eo});
		check("sleep", {7'h0, sleep}, {7'h0, es});
		check("mode", {6'h0, mode}, {6'h0, em});
		check("osc_active", {7'h0, osc_act}, {7'h0, oa});
		t = 0;
		prev = osc_clk;
		repeat (8) begin
			@(negedge core_clk_in);
			t += (osc_clk !== prev);
			prev = osc_clk;
		end
		check("osc_toggles", 8'(t), oa ? 8'h04 : 8'h00);
	endtask : check_outputs

	initial begin
		logic       a;
		logic [6:0] na;
		logic [7:0] d;
		core_clk_in = 1'b0;
		rst_n_in = 1'b0;
		lock = 1'b0;
		seed_v = $urandom(47388);
		strap = 3'($urandom);
		repeat (16) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		repeat (6) @(negedge core_clk_in);
		model_reset();
		check_outputs();
		check_regs();
		// Neighbouring address must be ignored
		u_dgc_host_model.write_reg(cur_dev() ^ 7'h01, 8'h02, 8'hFF, a);
		check("foreign_ack", {7'h0, a}, 8'h00);
		na = {2'b10, 5'($urandom)};
		wr(8'h00, {na, 1'b1});
		u_dgc_host_model.write_reg(ADDR_TAB[strap], 8'h02, 8'hFF, a);
		check("strap_ack", {7'h0, a}, 8'h00);
		wr(8'h01, {5'($urandom), 3'b000});
		wr(8'h02, 8'($urandom));
		check_regs();
		// Logic-only reset keeps every register
		wr(8'h01, {5'($urandom), 3'b001});
		check_regs();
		for (int i = 0; i < 32; i++) begin
			lock = i[4];
			d = {4'(i), 4'($urandom)};
			if (d[6] && d[7] && !mreg[2][7]) begin
				wr(8'h02, d);
				wr(8'h01, {mreg[1][7:3], 3'b001});
			end else begin
				wr(8'h02, d);
			end
			check_outputs();
		end
		check_regs();
		// Full reset reloads from a freshly changed strap
		strap = 3'($urandom);
		repeat (6) @(negedge core_clk_in);
		wr(8'h01, {5'h1F, 3'b010});
		check_regs();
		check_outputs();
		give_verdict();
	end
endmodule : deser_general_control_regs_bench
`default_nettype wire
